// ===== encoder_emulation_and_aux_input.sv
/*
  Encoder emulation output and secondary position input of a servo drive.
  Assumes MOTOR_POS comes from logic on CLK (no synchroniser) with 16 bits
  of turns over 16 bits of fraction; port pins are asynchronous.
*/
`timescale 1ns/10ps
`include "emu_defs.svh"

module encoder_emulation_and_aux_input (
  input  wire logic                CLK,                   // 20 MHz clock
  input  wire logic                RESET,                 // Sync reset, high
  input  wire logic [31:0]         MOTOR_POS,             // Primary position
  input  wire emu_pkg::source_e    SOURCE_SELECT,         // Secondary source
  input  wire emu_pkg::format_e    INPUT_FORMAT_SELECT,   // Input decoding
  input  wire logic [31:0]         INPUT_RESOLUTION,      // Counts per rev
  input  wire emu_pkg::emu_mode_e  EMULATION_MODE_SELECT, // Port function
  input  wire logic [15:0]         EMULATION_LINE_COUNT,  // Out counts/rev
  input  wire logic [15:0]         INDEX_FRACTION_OFFSET, // 65536 per rev
  input  wire logic [15:0]         INDEX_TURN_OFFSET,     // Whole revs
  input  wire logic                EMULATION_DIRECTION,   // 1 reverses
  input  wire logic                EMU_A_IN,              // Port A pin in
  input  wire logic                EMU_B_IN,              // Port B pin in
  input  wire logic                OPTO_A_IN,             // Opto A pin
  input  wire logic                OPTO_B_IN,             // Opto B pin
  output logic                     EMU_A_OUT,             // Emulated A
  output logic                     EMU_B_OUT,             // Emulated B
  output logic                     EMU_INDEX_OUT,         // Emulated index
  output logic                     EMU_OE,                // Port driving
  output logic [31:0]              FULL_OFFSET,           // Read-only
  output logic [31:0]              SECONDARY_POS,         // Pos in rev
  output logic [31:0]              SECONDARY_TURNS        // Ext revolutions
);
  import emu_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Gray A/B pair to binary phase 0..3
  function automatic logic [1:0] phase_of(input logic [1:0] ab);
    phase_of = {ab[1], ab[1] ^ ab[0]};
  endfunction : phase_of

  // Binary phase back to the A/B pair
  function automatic logic [1:0] ab_of(input logic [1:0] ph);
    ab_of = {ph[1], ph[1] ^ ph[0]};
  endfunction : ab_of

  state_s state;                        // Registered state
  state_s next_state;                   // Next state

  logic [1:0]        sel_ab;            // Selected synchronised A/B
  logic              in_enable;         // Input path live
  logic              step_up;           // One count forward
  logic              step_down;         // One count backward
  logic [1:0]        ph_diff;           // Phase change of quad input
  logic [31:0]       turn_scaled;       // Turns times line count
  logic [31:0]       frac_scaled;       // Fraction times line count
  logic [31:0]       target;            // Wanted emulated count
  logic [31:0]       gap;               // Target minus emitted
  logic [31:0]       sent;              // Count as seen outside
  logic [31:0]       full_pos;          // Index compare value
  logic              idx_eq;            // Index position reached
  logic              out_mode;          // Emulation output enabled

  // ----------------------------------------------------------------------
  // Input selection and decoding
  // ----------------------------------------------------------------------

  // Pick the source and decide whether counting is allowed
  always_comb begin
    unique case (SOURCE_SELECT)
      SRC_EMU:  sel_ab = state.sync2[1:0];
      SRC_OPTO: sel_ab = state.sync2[3:2];
      // No source: park at the idle level so a new source shows no false edge
      default:  sel_ab = 2'h0;
    endcase
    // source zero idle, port input only in modes 0 and 3, zero resolution
    in_enable = (SOURCE_SELECT == SRC_OPTO)
             || (SOURCE_SELECT == SRC_EMU && !out_mode);
    if (INPUT_RESOLUTION == `RST_COUNT) begin
      in_enable = 1'b0;
    end
  end

  // Turn edges into counts; source is trusted to keep dir stable at a step
  always_comb begin
    ph_diff   = phase_of(sel_ab) - phase_of(state.prev_ab);
    step_up   = 1'b0;
    step_down = 1'b0;
    unique case (INPUT_FORMAT_SELECT)
      FMT_QUAD: begin
        step_up   = (ph_diff == 2'h1);
        step_down = (ph_diff == 2'h3);
      end
      FMT_STEP_DIR: begin
        // direction level sampled at the step edge
        step_up   = sel_ab[1] && !state.prev_ab[1] && !sel_ab[0];
        step_down = sel_ab[1] && !state.prev_ab[1] && sel_ab[0];
      end
      FMT_UP_DOWN: begin
        step_up   = sel_ab[1] && !state.prev_ab[1];
        step_down = sel_ab[0] && !state.prev_ab[0];
        // Both lines at once cancel out
        if (step_up && step_down) begin
          step_up   = 1'b0;
          step_down = 1'b0;
        end
      end
      default: begin
        step_up   = 1'b0;
        step_down = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Emulation arithmetic
  // ----------------------------------------------------------------------

  // Target count and index compare from the motor position
  always_comb begin
    out_mode = (EMULATION_MODE_SELECT == EMODE_REV_IDX)
            || (EMULATION_MODE_SELECT == EMODE_ABS_IDX);
    // scale a revolution to the line count
    turn_scaled = 32'(MOTOR_POS[`TURN_MSB:`TURN_LSB] * EMULATION_LINE_COUNT);
    frac_scaled = 32'(MOTOR_POS[`FRAC_MSB:0] * EMULATION_LINE_COUNT);
    target      = turn_scaled + {16'h0000, frac_scaled[31:16]};
    gap         = target - state.out_count;
    // reversed direction counts the other way
    // Flipping it while driving jumps the phase; change it with output off
    sent        = EMULATION_DIRECTION ? (32'h0000_0000 - state.out_count)
                                      : state.out_count;
    // absolute compare, fraction on 65536 scale
    full_pos    = {INDEX_TURN_OFFSET, INDEX_FRACTION_OFFSET};
    unique case (EMULATION_MODE_SELECT)
      EMODE_REV_IDX: idx_eq = (MOTOR_POS[`FRAC_MSB:0] == INDEX_FRACTION_OFFSET);
      EMODE_ABS_IDX: idx_eq = (MOTOR_POS == full_pos);
      default:       idx_eq = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // All state updates in one place
  always_comb begin
    next_state         = state;
    // Two flops on each pin; only the second stage is read by logic
    // A above B in each pair, as sel_ab and the decoders expect
    next_state.sync1   = {OPTO_A_IN, OPTO_B_IN, EMU_A_IN, EMU_B_IN};
    next_state.sync2   = state.sync1;
    next_state.prev_ab = sel_ab;

    if (in_enable && step_up) begin
      if (state.in_pos >= INPUT_RESOLUTION - 32'h0000_0001) begin
        next_state.in_pos   = `RST_COUNT;
        next_state.in_turns = state.in_turns + 32'h0000_0001;
      end else begin
        next_state.in_pos   = state.in_pos + 32'h0000_0001;
      end
    end else if (in_enable && step_down) begin
      if (state.in_pos == `RST_COUNT) begin
        next_state.in_pos   = INPUT_RESOLUTION - 32'h0000_0001;
        next_state.in_turns = state.in_turns - 32'h0000_0001;
      end else begin
        next_state.in_pos   = state.in_pos - 32'h0000_0001;
      end
    end

    // one step per cycle keeps A/B a clean gray sequence
    if (!out_mode) begin
      // Follow silently so enabling output does not burst
      next_state.out_count = target;
    end else if (gap[31]) begin
      next_state.out_count = state.out_count - 32'h0000_0001;
    end else if (gap != 32'h0000_0000) begin
      next_state.out_count = state.out_count + 32'h0000_0001;
    end

    // mode sets direction of the port
    next_state.oe = out_mode;
    if (out_mode) begin
      {next_state.a_out, next_state.b_out} = ab_of(sent[1:0]);
    end else begin
      next_state.a_out = 1'b0;
      next_state.b_out = 1'b0;
    end

    // one pulse on arrival at the index point
    next_state.prev_eq   = idx_eq;
    next_state.index_out = idx_eq && !state.prev_eq;

    // read-only sum of turns and fraction
    next_state.full_offset = full_pos;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset to constants
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign EMU_A_OUT       = state.a_out;
  assign EMU_B_OUT       = state.b_out;
  assign EMU_INDEX_OUT   = state.index_out;
  assign EMU_OE          = state.oe;
  assign FULL_OFFSET     = state.full_offset;
  assign SECONDARY_POS   = state.in_pos;
  assign SECONDARY_TURNS = state.in_turns;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_no_input;
    !in_enable;
  endsequence

  sequence s_stable_count;
    ##1 $stable(state.in_pos) && $stable(state.in_turns);
  endsequence

  AST_SRC_NONE_IDLE: assert property (
    (SOURCE_SELECT == SRC_NONE) |-> s_stable_count)
    else $error("count moved with no source");

  AST_EMU_PORT_OUTPUT_NO_INPUT: assert property (
    (SOURCE_SELECT == SRC_EMU && out_mode) |-> s_no_input ##0 s_stable_count)
    else $error("emulation port counted while driving");

  AST_RES_ZERO_IDLE: assert property (
    (INPUT_RESOLUTION == 32'h0) |-> s_stable_count)
    else $error("count moved with zero resolution");

  AST_POS_IN_RANGE: assert property (
    (in_enable && $stable(INPUT_RESOLUTION)) |=> (state.in_pos < INPUT_RESOLUTION))
    else $error("position beyond resolution");

  AST_QUAD_UP: assert property (
    (in_enable && INPUT_FORMAT_SELECT == FMT_QUAD && ph_diff == 2'h1
     && state.in_pos < INPUT_RESOLUTION - 32'h1)
    |=> state.in_pos == $past(state.in_pos) + 32'h1)
    else $error("quadrature edge not counted");

  AST_OE_FOLLOWS_MODE: assert property (
    ##1 EMU_OE == $past(out_mode))
    else $error("drive enable wrong for mode");

  AST_GRAY_OUTPUT: assert property (
    EMU_OE && $past(EMU_OE) |-> !($changed(EMU_A_OUT) && $changed(EMU_B_OUT)))
    else $error("A and B changed together");

  AST_INDEX_REV: assert property (
    $rose(EMU_INDEX_OUT) && $past(EMULATION_MODE_SELECT) == EMODE_REV_IDX
    |-> $past(MOTOR_POS[15:0]) == $past(INDEX_FRACTION_OFFSET))
    else $error("index off the fraction offset");

  AST_INDEX_ABS: assert property (
    EMU_INDEX_OUT && $past(EMULATION_MODE_SELECT) == EMODE_ABS_IDX
    |-> $past(MOTOR_POS) == $past({INDEX_TURN_OFFSET, INDEX_FRACTION_OFFSET}))
    else $error("absolute index off full offset");

  AST_INDEX_ONE_CYCLE: assert property (
    EMU_INDEX_OUT |=> !EMU_INDEX_OUT)
    else $error("index wider than one cycle");

  AST_TRACK: assert property (
    out_mode && gap == 32'h0 && $stable(target) |=> state.out_count == $past(target))
    else $error("emulated count left a settled target");

  AST_PORT_QUIET: assert property (
    !out_mode |=> !EMU_OE && !EMU_A_OUT && !EMU_B_OUT && !EMU_INDEX_OUT)
    else $error("port outputs active in input mode");

  AST_STEP_DIR_DOWN: assert property (
    (in_enable && INPUT_FORMAT_SELECT == FMT_STEP_DIR && sel_ab == 2'h3 && !state.prev_ab[1]
     && state.in_pos != 32'h0)
    |=> state.in_pos == $past(state.in_pos) - 32'h1)
    else $error("step with direction down not counted");

  AST_UP_DOWN_UP: assert property (
    (in_enable && INPUT_FORMAT_SELECT == FMT_UP_DOWN && sel_ab == 2'h2 && state.prev_ab == 2'h0
     && state.in_pos < INPUT_RESOLUTION - 32'h1)
    |=> state.in_pos == $past(state.in_pos) + 32'h1)
    else $error("up line pulse not counted");

endmodule : encoder_emulation_and_aux_input

// ===== emu_defs.svh
/*
  Constants for the encoder emulation and secondary position input block:
  mode codes, field positions, reset values and source and format codes.
  Assumes inclusion by the package and by the top module only.
*/
// Functional notes
// - Source 0 takes no secondary position input.
// - Source 1 emulation port, 2 opto port.
// - Format 0 A/B, 1 step/dir, 2 up/down.
// - Input resolution sets counts per external revolution.
// - Mode 0 input, 1 per-rev index, 2 absolute.
// - Mode 0 port is input using format select.
// - Output A/B in quadrature plus index.
// - Line count sets output counts per revolution.
// - Mode 1 index where fraction equals offset.
// - Fraction offset scale fixed, 65536 per revolution.
// - Mode 2 index at turns plus fraction.
// - Full offset shown read-only.
// - Direction setting reverses emulated counting.
// - Resolutions count every quadrature edge.
// - Resolution zero produces no input command.
`ifndef EMU_DEFS_SVH
`define EMU_DEFS_SVH

// ----------------------------------------------------------------------
// Field layout of the motor position word
// ----------------------------------------------------------------------
`define POS_W         32
`define FRAC_W        16
`define FRAC_MSB      15
`define TURN_MSB      31
`define TURN_LSB      16

// ----------------------------------------------------------------------
// Mode, source and format codes
// ----------------------------------------------------------------------
`define SRC_NONE      2'h0
`define SRC_EMU       2'h1
`define SRC_OPTO      2'h2
`define FMT_QUAD      2'h0
`define FMT_STEP_DIR  2'h1
`define FMT_UP_DOWN   2'h2
`define EMODE_INPUT   2'h0
`define EMODE_REV_IDX 2'h1
`define EMODE_ABS_IDX 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_COUNT     32'h0000_0000
`define RST_PINS      4'h0
`define RST_BIT       1'b0

`endif

// ===== emu_pkg.sv
/*
  Types for the encoder emulation block: mode enums and the state record.
  Assumes emu_defs.svh is on the include path.
*/
`include "emu_defs.svh"

package emu_pkg;

  // ----------------------------------------------------------------------
  // Selections
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,                  // No secondary input
    SRC_EMU  = 2'b01,                  // Emulation port
    SRC_OPTO = 2'b10,                  // Opto input port
    SRC_RSVD = 2'b11                   // Treated as none
  } source_e;

  typedef enum logic [1:0] {
    FMT_QUAD     = 2'b00,              // A/B quadrature
    FMT_STEP_DIR = 2'b01,              // Step and direction
    FMT_UP_DOWN  = 2'b10,              // Up and down lines
    FMT_RSVD     = 2'b11               // Counts nothing
  } format_e;

  typedef enum logic [1:0] {
    EMODE_INPUT   = 2'b00,             // Port is an input
    EMODE_REV_IDX = 2'b01,             // Output, index every revolution
    EMODE_ABS_IDX = 2'b10,             // Output, absolute index
    EMODE_RSVD    = 2'b11              // Treated as input
  } emu_mode_e;

  // ----------------------------------------------------------------------
  // Whole state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]           sync1;       // First synchroniser stage
    logic [3:0]           sync2;       // Second synchroniser stage
    logic [1:0]           prev_ab;     // Selected A/B last cycle
    logic [`POS_W-1:0]    in_pos;      // Counts within external revolution
    logic [`POS_W-1:0]    in_turns;    // External revolutions
    logic [`POS_W-1:0]    out_count;   // Emulated count emitted so far
    logic                 prev_eq;     // Index match seen last cycle
    logic                 a_out;       // Emulated A
    logic                 b_out;       // Emulated B
    logic                 index_out;   // Emulated index
    logic                 oe;          // Port drives outputs
    logic [`POS_W-1:0]    full_offset; // Read-only full offset
  } state_s;

endpackage : emu_pkg

// ===== ext_source.sv
/*
  Far-side pulse source: an external controller that moves the secondary
  position input by one count per call, in A/B, step/dir or up/down form.
  Assumes the bench calls its tasks between clock edges.
*/
`timescale 1ns/10ps

module ext_source (
  input  wire logic clk,    // Bench clock
  output logic      line_a, // A, step or up line
  output logic      line_b  // B, direction or down line
);
  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  logic [1:0] phase; // Quadrature phase index

  initial begin
    line_a = 1'b0;
    line_b = 1'b0;
    phase  = 2'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // ----------------------------------------------------------------------
  // One count per call; every level held at least four cycles
  // ----------------------------------------------------------------------
  // gray phase step
  task automatic quad_step(input bit down);
    phase = down ? phase - 2'h1 : phase + 2'h1;
    @(posedge clk);
    line_a <= phase[1];
    line_b <= phase[1] ^ phase[0];
    hold(3);
  endtask : quad_step

  task automatic step_dir(input bit down);
    @(posedge clk);
    line_b <= down;
    hold(3);
    line_a <= 1'b1;
    hold(4);
    line_a <= 1'b0;
    hold(3);
  endtask : step_dir

  task automatic up_down(input bit down);
    @(posedge clk);
    if (down) line_b <= 1'b1;
    else line_a <= 1'b1;
    hold(4);
    line_a <= 1'b0;
    line_b <= 1'b0;
    hold(4);
  endtask : up_down

  // Lines parked low so a format change sees no edge
  task automatic idle();
    @(posedge clk);
    line_a <= 1'b0;
    line_b <= 1'b0;
    phase = 2'h0;
    hold(2);
  endtask : idle
endmodule : ext_source

// ===== tb_encoder_emulation_and_aux_input.sv
/*
  Self-checking bench for the encoder emulation block, with a count model.
  Assumes ext_source.sv and the design files are compiled first.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_encoder_emulation_and_aux_input;
  import emu_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk, reset, dirn, en_emu, en_opto, src_a, src_b; // Drives
  logic        a_out, b_out, idx_out, oe;                       // Port outputs
  logic [31:0] motor_pos, res_in, full_off, sec_pos, sec_turns; // Words
  logic [15:0] line_cnt, frac_off, turn_off;                    // Emulation set-up
  logic [1:0]  noise;                                           // Idle port pattern
  source_e     src_sel;                                         // Source
  format_e     fmt_sel;                                         // Format
  emu_mode_e   mode_sel;                                        // Port mode
  integer      seed = 32'hBA6A;                                 // Fixed seed
  int          num_errors = 0, checks_done = 0, exp_pos = 0, exp_turns = 0;
  int          res, lc, off, pulses, edges;                     // Test values

  encoder_emulation_and_aux_input DUT (
    .CLK(clk), .RESET(reset), .MOTOR_POS(motor_pos), .SOURCE_SELECT(src_sel),
    .INPUT_FORMAT_SELECT(fmt_sel), .INPUT_RESOLUTION(res_in), .EMULATION_MODE_SELECT(mode_sel),
    .EMULATION_LINE_COUNT(line_cnt), .INDEX_FRACTION_OFFSET(frac_off), .INDEX_TURN_OFFSET(turn_off),
    .EMULATION_DIRECTION(dirn), .EMU_A_IN(en_emu ? src_a : noise[1]), .EMU_B_IN(en_emu ? src_b : noise[0]),
    .OPTO_A_IN(en_opto ? src_a : noise[0]), .OPTO_B_IN(en_opto ? src_b : noise[1]), .EMU_A_OUT(a_out),
    .EMU_B_OUT(b_out), .EMU_INDEX_OUT(idx_out), .EMU_OE(oe), .FULL_OFFSET(full_off),
    .SECONDARY_POS(sec_pos), .SECONDARY_TURNS(sec_turns));

  ext_source src (.clk(clk), .line_a(src_a), .line_b(src_b));

  // ----------------------------------------------------------------------
  // Clock, unselected-port pattern, watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A port nobody drives toggles so a stale level never passes for silence
  always @(posedge clk) noise <= 2'($random(seed));

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Source goes to none while the route moves, so no switch edge is counted
  task automatic cfg(input int s, input int m, input int f, input int r);
    @(posedge clk);
    src_sel <= SRC_NONE;
    en_emu  <= (s != 2);
    en_opto <= (s != 1);
    src.idle();
    tick(4);
    src_sel  <= source_e'(s);
    mode_sel <= emu_mode_e'(m);
    fmt_sel  <= format_e'(f);
    res_in   <= 32'(r);
    tick(2);
  endtask : cfg

  // Random counts through the far side, model updated and compared
  task automatic steps(input int n);
    bit dn;
    bit act;
    repeat (n) begin
      dn = 1'($random(seed));
      case (fmt_sel)
        FMT_QUAD:     src.quad_step(dn);
        FMT_STEP_DIR: src.step_dir(dn);
        default:      src.up_down(dn);
      endcase
      tick(3);
      act = ((src_sel == SRC_EMU && mode_sel inside {EMODE_INPUT, EMODE_RSVD}) || src_sel == SRC_OPTO)
            && res_in != 0 && fmt_sel != FMT_RSVD;
      if (act && !dn) begin
        exp_pos = (exp_pos == res - 1) ? 0 : exp_pos + 1;
        exp_turns += int'(exp_pos == 0);
      end else if (act) begin
        exp_turns -= int'(exp_pos == 0);
        exp_pos = (exp_pos == 0) ? res - 1 : exp_pos - 1;
      end
      #1;
      `CHK(sec_pos, 32'(exp_pos))
      `CHK(sec_turns, 32'(exp_turns))
    end
  endtask : steps

  task automatic chk_ab(input int c);
    logic [31:0] cc;
    cc = c;
    `CHK({a_out, b_out}, {cc[1], cc[1] ^ cc[0]})
  endtask : chk_ab

  // One motor revolution in 256 steps; counts A/B edges and index pulses
  task automatic sweep(input int turn, output int np, output int ne);
    logic [1:0]  last;
    logic [31:0] h1, h2;
    np = 0;
    ne = 0;
    @(posedge clk);
    motor_pos <= 32'(turn * 65536);
    tick(200);
    #1;
    last = {a_out, b_out};
    h1 = motor_pos;
    h2 = motor_pos;
    for (int i = 1; i <= 260; i++) begin
      @(posedge clk);
      motor_pos <= 32'(turn * 65536 + ((i > 256) ? 256 : i) * 256);
      #1;
      if (idx_out === 1'b1) begin
        np++;
        `CHK((h1[15:0] === frac_off) || (h2[15:0] === frac_off), 1'b1)
      end
      ne += int'(a_out !== last[1]) + int'(b_out !== last[0]);
      last = {a_out, b_out};
      h2 = h1;
      h1 = motor_pos;
    end
  endtask : sweep

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1; motor_pos = 32'h0; src_sel = SRC_NONE; fmt_sel = FMT_QUAD;
    mode_sel = EMODE_INPUT; res_in = 32'h0; line_cnt = 16'h0; frac_off = 16'h0;
    turn_off = 16'h0; dirn = 1'b0; en_emu = 1'b1; en_opto = 1'b1;
    tick(3);
    reset <= 1'b0;
    #1;
    `CHK({a_out, b_out, idx_out, oe, sec_pos, sec_turns, full_off}, 100'h0)
    res = 3 + $unsigned($random(seed)) % 4;
    // Sources 1 and 2 with formats 0 to 2, small resolution so wraps occur
    for (int s = 1; s <= 2; s++) for (int f = 0; f <= 2; f++) begin
      cfg(s, 0, f, res);
      steps(12);
    end
    $display("test input decode done");
    cfg(0, 0, 0, res); steps(4);
    cfg(1, 1, 0, res); steps(4);
    cfg(2, 0, 3, res); steps(4);
    cfg(2, 0, 0, 0);   steps(4);
    $display("test refused input done");
    lc  = 8 + $unsigned($random(seed)) % 25;
    off = 256 + ($unsigned($random(seed)) % 253) * 256;
    @(posedge clk);
    line_cnt <= 16'(lc);
    frac_off <= 16'(off);
    mode_sel <= EMODE_REV_IDX;
    sweep(0, pulses, edges);
    `CHK(edges, lc)
    `CHK(pulses, 1)
    chk_ab(lc);
    `CHK(oe, 1'b1)
    // Direction flipped only while the port is quiet, so A/B never jump
    @(posedge clk);
    mode_sel <= EMODE_INPUT;
    dirn     <= 1'b1;
    tick(2);
    mode_sel <= EMODE_REV_IDX;
    tick(150);
    #1;
    chk_ab(-lc);
    $display("test emulation rev index done");
    @(posedge clk);
    mode_sel <= EMODE_ABS_IDX;
    turn_off <= 16'h0002;
    tick(2);
    #1;
    `CHK(full_off, {16'h0002, frac_off})
    sweep(1, pulses, edges);
    `CHK(pulses, 0)
    sweep(2, pulses, edges);
    `CHK(pulses, 1)
    @(posedge clk);
    mode_sel <= EMODE_INPUT;
    tick(3);
    #1;
    `CHK({oe, a_out, b_out, idx_out}, 4'h0)
    $display("test emulation abs index done");
    @(posedge clk);
    reset <= 1'b1;
    tick(2);
    #1;
    `CHK({sec_pos, sec_turns}, 64'h0)
    @(posedge clk);
    reset <= 1'b0;
    exp_pos   = 0;
    exp_turns = 0;
    cfg(2, 0, 0, res); steps(4);
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb_encoder_emulation_and_aux_input
